/* hw/ufcd_flag_data_regs.v */
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ufcd_regs.vh"

module ufcd_flag_data_regs
(
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`UFCD_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire [`UFCD_FLAG_W-1:0] flagSetEvents,
    input wire rxCharValid,
    input wire [`UFCD_CHAR_W-1:0] rxCharData,
    input wire txCharTaken,
    output wire txCharPending,
    output reg [`UFCD_CHAR_W-1:0] txChar,
    output wire parityEnable,
    output wire parityOdd,
    output wire nineBitWord
);

// ****************************************************************
// Reset release
// ****************************************************************
// Assertion is immediate; release passes two flops
reg [1:0] rstSync_reg;
wire rstn;

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        rstSync_reg <= `UFCD_RST_SYNC;
    else
        rstSync_reg <= {rstSync_reg[0], 1'b1};
end

assign rstn = rstSync_reg[1];

// ****************************************************************
// Bus decode
// ****************************************************************
wire setupPhase;
wire accessPhase;
wire writeAccess;
wire readAccess;
wire hitControl;
wire hitStatus;
wire hitClear;
wire hitReceive;
wire hitTransmit;
wire hitAny;
wire [31:0] laneMask;
wire [31:0] maskedData;

assign setupPhase = psel & ~penable;
assign accessPhase = psel & penable;
assign hitControl = (paddr == `UFCD_OFF_CONTROL);
assign hitStatus = (paddr == `UFCD_OFF_STATUS);
assign hitClear = (paddr == `UFCD_OFF_FLAG_CLEAR);
assign hitReceive = (paddr == `UFCD_OFF_RECEIVE);
assign hitTransmit = (paddr == `UFCD_OFF_TRANSMIT);
assign hitAny = hitControl | hitStatus | hitClear | hitReceive | hitTransmit;
assign writeAccess = accessPhase & pwrite & hitAny;
assign readAccess = accessPhase & ~pwrite & hitAny;
// Byte lanes gate the write data
assign laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
assign maskedData = pwdata & laneMask;

// Zero wait states; unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = accessPhase & ~hitAny;

// ****************************************************************
// Control register
// ****************************************************************
// Lane 0 carries every control bit
reg [`UFCD_CTL_W-1:0] control_reg;

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        control_reg <= `UFCD_RST_CONTROL;
    else if (writeAccess & hitControl & pstrb[0])
        control_reg <= pwdata[`UFCD_CTL_W-1:0];
end

assign parityEnable = control_reg[`UFCD_CTL_PARITY_EN];
assign parityOdd = control_reg[`UFCD_CTL_PARITY_ODD];
assign nineBitWord = control_reg[`UFCD_CTL_NINE_BIT];

// ****************************************************************
// Flag-clear decode
// ****************************************************************
wire clearWrite;
wire parityErrClear;
wire framingErrClear;
wire noiseClear;
wire overrunClear;
wire idleLineClear;
wire txCompleteClear;
wire breakDetectClear;
wire clearToSendChangeClear;
wire rxTimeoutClear;
wire blockEndClear;
wire charMatchClear;
wire stopWakeupClear;
wire txWriteClear;
wire [`UFCD_FLAG_W-1:0] clearVec;
wire [`UFCD_FLAG_W-1:0] setVec;

assign clearWrite = writeAccess & hitClear;
assign parityErrClear = clearWrite & maskedData[`UFCD_BIT_PE];
assign framingErrClear = clearWrite & maskedData[`UFCD_BIT_FE];
assign noiseClear = clearWrite & maskedData[`UFCD_BIT_NE];
assign overrunClear = clearWrite & maskedData[`UFCD_BIT_OVR];
assign idleLineClear = clearWrite & maskedData[`UFCD_BIT_IDLE];
assign txCompleteClear = clearWrite & maskedData[`UFCD_BIT_TXC];
assign breakDetectClear = clearWrite & maskedData[`UFCD_BIT_LBD];
assign clearToSendChangeClear = clearWrite & maskedData[`UFCD_BIT_CTS];
assign rxTimeoutClear = clearWrite & maskedData[`UFCD_BIT_RXTO];
assign blockEndClear = clearWrite & maskedData[`UFCD_BIT_EOB];
assign charMatchClear = clearWrite & maskedData[`UFCD_BIT_CM];
assign stopWakeupClear = clearWrite & maskedData[`UFCD_BIT_WSM];

// Reserved positions never clear anything
assign clearVec = {stopWakeupClear,
                   2'b00,
                   charMatchClear,
                   4'h0,
                   blockEndClear,
                   rxTimeoutClear,
                   1'b0,
                   clearToSendChangeClear,
                   breakDetectClear,
                   1'b0,
                   txCompleteClear | txWriteClear,
                   1'b0,
                   idleLineClear,
                   overrunClear,
                   noiseClear,
                   framingErrClear,
                   parityErrClear};

// ****************************************************************
// Transmit data register
// ****************************************************************
wire txWrite;
wire [`UFCD_CHAR_W-1:0] txWritten;
wire txParityWide;
wire txParityNarrow;
wire txParityBit;
reg [`UFCD_CHAR_W-1:0] txLoad;
reg txBufferEmpty_reg;
reg txBufferEmpty_next;

assign txWrite = writeAccess & hitTransmit & pstrb[0];
assign txWriteClear = txWrite;
assign txWritten = {pstrb[1] & pwdata[`UFCD_CHAR_MSB], pwdata[`UFCD_BYTE_MSB:0]};
assign txParityWide = ^pwdata[`UFCD_BYTE_MSB:0];
assign txParityNarrow = ^pwdata[`UFCD_SEVEN_MSB:0];
assign txParityBit = parityOdd ^ (nineBitWord ? txParityWide : txParityNarrow);

// Parity takes the top data bit; bit 8 is unused in 8-bit mode
always @*
begin
    txLoad = txWritten;
    if (parityEnable)
    begin
        if (nineBitWord)
            txLoad[`UFCD_CHAR_MSB] = txParityBit;
        else
            txLoad[`UFCD_BYTE_MSB] = txParityBit;
    end
    if (!nineBitWord)
        txLoad[`UFCD_CHAR_MSB] = 1'b0;
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        txChar <= `UFCD_RST_CHAR;
    else if (txWrite)
        txChar <= txLoad;
end

// Shifter taking the character in the write cycle leaves the buffer full
always @*
begin
    txBufferEmpty_next = txBufferEmpty_reg;
    if (txCharTaken)
        txBufferEmpty_next = 1'b1;
    if (txWrite)
        txBufferEmpty_next = 1'b0;
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        txBufferEmpty_reg <= `UFCD_RST_TX_EMPTY;
    else
        txBufferEmpty_reg <= txBufferEmpty_next;
end

assign txCharPending = ~txBufferEmpty_reg;

// ****************************************************************
// Receive data register
// ****************************************************************
wire rxRead;
wire rxOverrun;
reg [`UFCD_CHAR_W-1:0] rxChar_reg;
reg rxBufferFull_reg;
reg rxBufferFull_next;

assign rxRead = readAccess & hitReceive;
assign rxOverrun = rxCharValid & rxBufferFull_reg & ~rxRead;

// Unread character is kept on overrun
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        rxChar_reg <= `UFCD_RST_CHAR;
    else if (rxCharValid & ~rxOverrun)
        rxChar_reg <= rxCharData;
end

// Read empties the buffer; an arrival in the same cycle wins
always @*
begin
    rxBufferFull_next = rxBufferFull_reg;
    if (rxRead)
        rxBufferFull_next = 1'b0;
    if (rxCharValid)
        rxBufferFull_next = 1'b1;
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        rxBufferFull_reg <= `UFCD_RST_BIT;
    else
        rxBufferFull_reg <= rxBufferFull_next;
end

// ****************************************************************
// Status flags
// ****************************************************************
reg [`UFCD_FLAG_W-1:0] flags_reg;
wire [`UFCD_FLAG_W-1:0] overrunSet;

// Overrun is raised here as well as by the shifter
assign overrunSet = {{(`UFCD_FLAG_W-1){1'b0}}, rxOverrun} << `UFCD_BIT_OVR;
assign setVec = (flagSetEvents | overrunSet) & `UFCD_CLEAR_MASK;

// Set beats clear so no event is lost
genvar i;
generate
    for (i = 0; i < `UFCD_FLAG_W; i = i + 1)
    begin : gFlag
        always @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                flags_reg[i] <= `UFCD_RST_BIT;
            else if (setVec[i])
                flags_reg[i] <= 1'b1;
            else if (clearVec[i])
                flags_reg[i] <= 1'b0;
        end
    end
endgenerate

// ****************************************************************
// Read data
// ****************************************************************
wire [31:0] statusWord;
wire [`UFCD_CHAR_W-1:0] rxVisible;
reg [31:0] readMux;

assign statusWord = {11'h000,
                     flags_reg[`UFCD_FLAG_MSB:`UFCD_BIT_LBD],
                     txBufferEmpty_reg,
                     flags_reg[`UFCD_BIT_TXC],
                     rxBufferFull_reg,
                     flags_reg[`UFCD_BIT_IDLE:`UFCD_BIT_PE]};

// Parity bit arrives from the shifter in the character MSB
assign rxVisible = nineBitWord ? rxChar_reg :
                   {1'b0, rxChar_reg[`UFCD_BYTE_MSB:0]};

// Reserved bits and the flag-clear register read as zero
always @*
begin
    readMux = `UFCD_RST_WORD;
    if (hitControl)
        readMux = {29'h00000000, control_reg};
    else if (hitStatus)
        readMux = statusWord;
    else if (hitClear)
        readMux = `UFCD_RST_WORD;
    else if (hitReceive)
        readMux = {23'h000000, rxVisible};
    else if (hitTransmit)
        readMux = {23'h000000, txChar};
end

// Sampled in the setup cycle so the access phase sees stable data
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        prdata <= `UFCD_RST_WORD;
    else if (setupPhase & ~pwrite)
        prdata <= readMux;
end

endmodule
`default_nettype wire

/* common/ufcd_regs.vh */
`ifndef UFCD_REGS_VH
`define UFCD_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define UFCD_ADDR_W 8
`define UFCD_OFF_CONTROL 8'h00
`define UFCD_OFF_STATUS 8'h1C
`define UFCD_OFF_FLAG_CLEAR 8'h20
`define UFCD_OFF_RECEIVE 8'h24
`define UFCD_OFF_TRANSMIT 8'h28

// ****************************************************************
// Reset values
// ****************************************************************
`define UFCD_RST_CONTROL 3'h0
`define UFCD_RST_FLAGS 21'h000000
`define UFCD_RST_CHAR 9'h000
`define UFCD_RST_WORD 32'h00000000
`define UFCD_RST_SYNC 2'h0
`define UFCD_RST_BIT 1'h0
`define UFCD_RST_TX_EMPTY 1'h1

// ****************************************************************
// Control fields
// ****************************************************************
`define UFCD_CTL_W 3
`define UFCD_CTL_PARITY_EN 0
`define UFCD_CTL_PARITY_ODD 1
`define UFCD_CTL_NINE_BIT 2

// ****************************************************************
// Status and flag-clear bit positions
// ****************************************************************
`define UFCD_FLAG_W 21
`define UFCD_FLAG_MSB 20
`define UFCD_BIT_PE 0
`define UFCD_BIT_FE 1
`define UFCD_BIT_NE 2
`define UFCD_BIT_OVR 3
`define UFCD_BIT_IDLE 4
`define UFCD_BIT_RXFULL 5
`define UFCD_BIT_TXC 6
`define UFCD_BIT_TXE 7
`define UFCD_BIT_LBD 8
`define UFCD_BIT_CTS 9
`define UFCD_BIT_RXTO 11
`define UFCD_BIT_EOB 12
`define UFCD_BIT_CM 17
`define UFCD_BIT_WSM 20
`define UFCD_CLEAR_MASK 21'h121B5F

// ****************************************************************
// Character fields
// ****************************************************************
`define UFCD_CHAR_W 9
`define UFCD_CHAR_MSB 8
`define UFCD_BYTE_MSB 7
`define UFCD_SEVEN_MSB 6

`endif

/* sim/ufcd_flag_data_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufcd_regs.vh"
module ufcd_flag_data_regs_chk
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`UFCD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic txCharTaken,
    input wire logic txCharPending,
    input wire logic [`UFCD_CHAR_W-1:0] txChar,
    input wire logic parityEnable,
    input wire logic parityOdd,
    input wire logic nineBitWord
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic txWr = psel && penable && pwrite && pstrb[0] && paddr == `UFCD_OFF_TRANSMIT;
    wire logic rdSetup = psel && !penable && !pwrite;
    wire logic mapped = paddr inside {`UFCD_OFF_CONTROL, `UFCD_OFF_STATUS, `UFCD_OFF_FLAG_CLEAR,
        `UFCD_OFF_RECEIVE, `UFCD_OFF_TRANSMIT};
    a_tx_load_char: assert property (txWr |=> txCharPending && txChar[6:0] == $past(pwdata[6:0]))
        else $error("transmit char not loaded");
    a_tx_parity_nine: assert property (txWr && parityEnable && nineBitWord
        |=> txChar[8] == (^$past(pwdata[7:0]) ^ $past(parityOdd))) else $error("nine-bit parity wrong");
    a_tx_parity_eight: assert property (txWr && parityEnable && !nineBitWord
        |=> txChar[8:7] == {1'b0, ^$past(pwdata[6:0]) ^ $past(parityOdd)}) else $error("eight-bit parity wrong");
    a_tx_plain_nine: assert property (txWr && !parityEnable && nineBitWord
        |=> txChar[8:7] == $past(pwdata[8:7])) else $error("plain char wrong");
    a_tx_taken_drop: assert property (txCharTaken && !txWr |=> !txCharPending)
        else $error("pending kept after take");
    a_tx_pending_hold: assert property (txCharPending && !txCharTaken && !txWr
        |=> txCharPending && $stable(txChar)) else $error("pending char lost");
    a_clear_reads_zero: assert property (rdSetup && paddr == `UFCD_OFF_FLAG_CLEAR |=> prdata == 32'h0)
        else $error("flag clear read not zero");
    a_rx_upper_zero: assert property (rdSetup && paddr == `UFCD_OFF_RECEIVE |=> prdata[31:9] == 23'h0)
        else $error("receive upper bits set");
    a_unmapped_error: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped address");
endmodule
bind ufcd_flag_data_regs ufcd_flag_data_regs_chk chk_u (.*);
`default_nettype wire

/* sim/ufcd_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufcd_regs.vh"
module ufcd_line_model #(parameter int TAKE_DELAY = 8)
(
    input wire logic clk,
    input wire logic txCharPending,
    input wire logic [`UFCD_CHAR_W-1:0] txChar,
    output logic rxCharValid,
    output logic [`UFCD_CHAR_W-1:0] rxCharData,
    output logic txCharTaken,
    output logic [`UFCD_CHAR_W-1:0] lastTx
);
    int waitCnt = 0;
    initial
    begin
        rxCharValid = 1'b0;
        rxCharData = 9'h0AA;
        txCharTaken = 1'b0;
        lastTx = 9'h000;
    end
    // ****
    // Transmit shifter takes a pending char after a delay
    // ****
    always @(posedge clk)
    begin
        txCharTaken <= 1'b0;
        if (txCharPending && !txCharTaken && waitCnt == TAKE_DELAY)
        begin
            txCharTaken <= 1'b1;
            lastTx <= txChar;
            waitCnt <= 0;
        end
        else
            waitCnt <= txCharPending ? waitCnt + 1 : 0;
    end
    task automatic sendChar(input logic [`UFCD_CHAR_W-1:0] c);
        @(posedge clk);
        rxCharValid <= 1'b1;
        rxCharData <= c;
        @(posedge clk);
        rxCharValid <= 1'b0;
        rxCharData <= ~c;
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufcd_regs.vh"
module tb_top;
    logic clk = 0;
    logic resetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [20:0] flagSetEvents = 0;
    logic pready, pslverr, rxCharValid, txCharTaken, txCharPending;
    logic [31:0] prdata;
    logic [8:0] rxCharData, txChar, lastTx;
    int mismatches = 0;
    int checkCount = 0;
    int cycles = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    ufcd_flag_data_regs dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .flagSetEvents(flagSetEvents), .rxCharValid(rxCharValid), .rxCharData(rxCharData),
        .txCharTaken(txCharTaken), .txCharPending(txCharPending), .txChar(txChar),
        .parityEnable(), .parityOdd(), .nineBitWord());
    ufcd_line_model line_u (.clk(clk), .txCharPending(txCharPending), .txChar(txChar),
        .rxCharValid(rxCharValid), .rxCharData(rxCharData), .txCharTaken(txCharTaken), .lastTx(lastTx));
    task automatic test_done();
        if (mismatches == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // ****
    // Bus transfers
    // ****
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [20:0] ev,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        flagSetEvents <= ev;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        flagSetEvents <= 21'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 21'h0, r, e);
    endtask
    task automatic chkRd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 21'h0, r, e);
        cmp(what, exp, r);
    endtask
    function automatic logic [31:0] txExpect(input logic [2:0] c, input logic [8:0] d);
        if (!c[0])
            return {23'h0, c[2] & d[8], d[7:0]};
        if (c[2])
            return {23'h0, ^d[7:0] ^ c[1], d[7:0]};
        return {23'h0, 1'b0, ^d[6:0] ^ c[1], d[6:0]};
    endfunction
    // ****
    // Scenarios
    // ****
    task automatic t_flag_clear();
        int pos[12] = '{0, 1, 2, 3, 4, 6, 8, 9, 11, 12, 17, 20};
        logic [31:0] m, r;
        logic e;
        chkRd(`UFCD_OFF_FLAG_CLEAR, 32'h0, "flag clear reset");
        foreach (pos[i])
        begin
            m = 32'h1 << pos[i];
            apb(1'b1, `UFCD_OFF_FLAG_CLEAR, 32'h0, m[20:0], r, e);
            chkRd(`UFCD_OFF_STATUS, m | 32'h80, "zero write");
            apb(1'b1, `UFCD_OFF_FLAG_CLEAR, m, m[20:0], r, e);
            chkRd(`UFCD_OFF_STATUS, m | 32'h80, "set wins");
            wr(`UFCD_OFF_FLAG_CLEAR, m);
            chkRd(`UFCD_OFF_STATUS, 32'h80, "one clears");
        end
    endtask
    task automatic t_reserved();
        logic [31:0] r;
        logic e;
        line_u.sendChar(9'h055);
        apb(1'b1, `UFCD_OFF_FLAG_CLEAR, 32'h0, `UFCD_CLEAR_MASK, r, e);
        wr(`UFCD_OFF_FLAG_CLEAR, 32'hFFFFFFFF);
        chkRd(`UFCD_OFF_STATUS, 32'hA0, "reserved clear");
        chkRd(`UFCD_OFF_RECEIVE, 32'h055, "rx char");
        apb(1'b0, 8'h30, 32'h0, 21'h0, r, e);
        cmp("unmapped error", 32'h1, {31'h0, e});
    endtask
    task automatic t_receive(input logic [2:0] c, input logic [8:0] d, input logic [31:0] exp);
        wr(`UFCD_OFF_CONTROL, {29'h0, c});
        chkRd(`UFCD_OFF_CONTROL, {29'h0, c}, "control readback");
        line_u.sendChar(d);
        chkRd(`UFCD_OFF_STATUS, 32'hA0, "rx not empty");
        chkRd(`UFCD_OFF_RECEIVE, exp, "rx parity char");
        chkRd(`UFCD_OFF_STATUS, 32'h80, "rx read");
    endtask
    task automatic t_transmit(input logic [2:0] c, input logic [8:0] d);
        int n = 0;
        logic [31:0] r;
        logic e;
        wr(`UFCD_OFF_CONTROL, {29'h0, c});
        apb(1'b1, `UFCD_OFF_FLAG_CLEAR, 32'h0, 21'h40, r, e);
        wr(`UFCD_OFF_TRANSMIT, {23'h0, d});
        chkRd(`UFCD_OFF_STATUS, 32'h0, "tx write flags");
        chkRd(`UFCD_OFF_TRANSMIT, txExpect(c, d), "tx readback");
        while (txCharPending !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        cmp("tx char", txExpect(c, d), {23'h0, lastTx});
        chkRd(`UFCD_OFF_STATUS, 32'h80, "tx empty");
    endtask
    task automatic t_overrun();
        line_u.sendChar(9'h033);
        line_u.sendChar(9'h044);
        chkRd(`UFCD_OFF_STATUS, 32'hA8, "overrun flags");
        chkRd(`UFCD_OFF_RECEIVE, 32'h033, "overrun keeps char");
        wr(`UFCD_OFF_FLAG_CLEAR, 32'h8);
        chkRd(`UFCD_OFF_STATUS, 32'h80, "overrun cleared");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chkRd(`UFCD_OFF_STATUS, 32'h80, "status reset");
        t_flag_clear();
        t_reserved();
        t_overrun();
        t_receive(3'b101, 9'h1A5, 32'h1A5);
        t_receive(3'b001, 9'h1A5, 32'h0A5);
        t_transmit(3'b101, 9'h0D3);
        t_transmit(3'b111, 9'h0D3);
        t_transmit(3'b001, 9'h1D3);
        t_transmit(3'b011, 9'h153);
        t_transmit(3'b100, 9'h1D3);
        t_transmit(3'b000, 9'h1D3);
        test_done();
    end
endmodule
`default_nettype wire
